// *** rtl/ssbg_pkg.sv ***
package ssbg_pkg;

    // ==========================================================
    // register map
    localparam logic [1:0] SSBG_STATUS_ADDR = 2'h0;
    localparam logic [1:0] SSBG_DIVISOR_ADDR = 2'h1;
    localparam logic [1:0] SSBG_CONTROL_ADDR = 2'h2;

    // ==========================================================
    // status field positions
    localparam int SSBG_TX_EMPTY_BIT = 7;
    localparam int SSBG_RX_FULL_BIT = 6;
    localparam int SSBG_OVERRUN_BIT = 5;
    localparam int SSBG_FRAMING_BIT = 4;
    localparam int SSBG_PARITY_BIT = 3;
    localparam int SSBG_TX_DONE_BIT = 2;
    localparam int SSBG_RX_MPB_BIT = 1;
    localparam int SSBG_TX_MPB_BIT = 0;

    // control field positions
    localparam int SSBG_SYNC_MODE_BIT = 7;
    localparam int SSBG_PRESCALE_LSB = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0] SSBG_STATUS_RESET = 8'h84;
    localparam logic [7:0] SSBG_DIVISOR_RESET = 8'hff;
    localparam logic [7:0] SSBG_CONTROL_RESET = 8'h00;

    // ==========================================================
    // timing: divider ticks per bit
    localparam logic [4:0] SSBG_ASYNC_PHASE_LAST = 5'h1f;
    localparam logic [4:0] SSBG_SYNC_PHASE_LAST = 5'h03;

    // prescaler mask: phi, phi/4, phi/16, phi/64
    function automatic logic [5:0] ssbg_pre_mask(input logic [1:0] n);
        case (n)
            2'h0: ssbg_pre_mask = 6'h00;
            2'h1: ssbg_pre_mask = 6'h03;
            2'h2: ssbg_pre_mask = 6'h0f;
            default: ssbg_pre_mask = 6'h3f;
        endcase
    endfunction : ssbg_pre_mask

    // clock cycles per bit for a divisor, prescale and mode
    function automatic logic [19:0] ssbg_bit_period(input logic [7:0] div,
            input logic [1:0] n, input logic sync_mode);
        logic [19:0] base;
        base = 20'({12'h000, div} + 20'h00001) << (2 * n);
        ssbg_bit_period = sync_mode ? 20'(base << 2) : 20'(base << 5);
    endfunction : ssbg_bit_period

endpackage : ssbg_pkg

// *** rtl/ssbg_baud_if.sv ***
`timescale 1ns/1ps
interface ssbg_baud_if;
    logic [7:0] divisor;
    logic [1:0] prescale;
    logic sync_mode;
    logic restart;
    logic bit_tick;

    modport ctrl (output divisor, output prescale, output sync_mode, output restart,
                  input bit_tick);
    modport gen (input divisor, input prescale, input sync_mode, input restart,
                 output bit_tick);
endinterface : ssbg_baud_if

// *** rtl/ssbg_flag_cell.sv ***
`timescale 1ns/1ps
module ssbg_flag_cell #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic set_i,
    input wire logic hw_clr_i,
    input wire logic sts_rd_i,
    input wire logic sts_wr_i,
    input wire logic wbit_i,
    output logic flag_o
);
    logic flag_reg;
    logic armed_reg;
    logic sw_clr;

    // ==========================================================
    // clear only by a 0 written after a read that returned 1
    assign sw_clr = sts_wr_i && !wbit_i && armed_reg;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            armed_reg <= 1'b0;
        end else if (sts_rd_i) begin
            armed_reg <= flag_reg;
        end else if (sts_wr_i) begin
            armed_reg <= 1'b0;
        end
    end

    // set beats any clear so no event is lost; writing 1 does nothing
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_reg <= RESET_VAL;
        end else if (set_i) begin
            flag_reg <= 1'b1;
        end else if (sw_clr || hw_clr_i) begin
            flag_reg <= 1'b0;
        end
    end

    assign flag_o = flag_reg;

    set_wins_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        set_i |=> flag_reg) else $error("flag lost a set");
endmodule : ssbg_flag_cell

// *** rtl/ssbg_baud_gen.sv ***
`timescale 1ns/1ps
module ssbg_baud_gen
    import ssbg_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    ssbg_baud_if.gen baud
);
    logic [5:0] pre_reg;
    logic [7:0] div_reg;
    logic [4:0] phase_reg;
    logic tick_reg;
    logic pre_tick;
    logic div_tick;
    logic [4:0] phase_last;

    // ==========================================================
    // prescaler, divisor counter, bit phase
    assign pre_tick = (pre_reg & ssbg_pre_mask(baud.prescale)) == ssbg_pre_mask(baud.prescale);
    assign div_tick = pre_tick && (div_reg == 8'h00);
    assign phase_last = baud.sync_mode ? SSBG_SYNC_PHASE_LAST : SSBG_ASYNC_PHASE_LAST;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pre_reg <= 6'h00;
        end else if (baud.restart) begin
            pre_reg <= 6'h00;
        end else begin
            pre_reg <= pre_reg + 6'h01;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_reg <= SSBG_DIVISOR_RESET;
        end else if (baud.restart || div_tick) begin
            div_reg <= baud.divisor;
        end else if (pre_tick) begin
            div_reg <= div_reg - 8'h01;
        end
    end

    // >= rather than == so a mode change mid-count cannot overshoot
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_reg <= 5'h00;
            tick_reg <= 1'b0;
        end else if (baud.restart) begin
            phase_reg <= 5'h00;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= div_tick && (phase_reg >= phase_last);
            if (div_tick) begin
                phase_reg <= (phase_reg >= phase_last) ? 5'h00 : phase_reg + 5'h01;
            end
        end
    end

    assign baud.bit_tick = tick_reg;

    // ==========================================================
    // checking: cycles between bit ticks
    logic [19:0] gap_reg;
    logic seen_reg;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gap_reg <= 20'h00000;
            seen_reg <= 1'b0;
        end else begin
            gap_reg <= (tick_reg || baud.restart) ? 20'h00000 : gap_reg + 20'h00001;
            seen_reg <= baud.restart ? 1'b0 : (seen_reg || tick_reg);
        end
    end

    bit_period_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (tick_reg && seen_reg)
        |-> gap_reg == ssbg_bit_period(baud.divisor, baud.prescale, baud.sync_mode) - 20'h1)
        else $error("bit period wrong");

    fastest_rate_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (tick_reg && seen_reg && baud.divisor == 8'h00 && baud.prescale == 2'h0
         && !baud.sync_mode) |-> gap_reg == 20'd31)
        else $error("fastest async rate not phi/32");
endmodule : ssbg_baud_gen

// *** rtl/ssbg_top.sv ***
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
// Behaviour
// - tx buffer empty resets to 1; set when tx disabled or holding moves to shift.
// - tx buffer empty clears on 0 written after reading 1, or tx data write.
// - rx buffer full resets to 0; set when a good byte reaches holding register.
// - rx buffer full clears on 0 written after reading 1, or holding register read.
// - overrun resets to 0, set on overrun, cleared only by 0 after read 1.
// - framing flag resets to 0, set on framing error, cleared by 0 after 1.
// - parity flag resets to 0, set on parity mismatch, cleared by 0 after 1.
// - tx complete resets to 1; set when tx disabled or last bit with buffer empty.
// - tx complete clears by 0 after read 1 or tx data write; never set by software.
// - rx multiprocessor bit captures each received one, holds when rx disabled, resets 0.
// - tx multiprocessor bit is read/write, resets to 0, appended to each character.
// - divisor is 8-bit read/write, resets to all ones, takes any value 0..255.
// - async bit rate is phi over 64 times 2^(2n-1) times divisor plus one.
// - clocked sync bit rate is phi over 8 times 2^(2n-1) times divisor plus one.
// - async divisor 0 with prescale 0 gives phi/32, the fastest rate.
// - writing 1 to the six clear-only status flags has no effect.
// - two-bit prescale picks phi undivided for 00 up to phi/64 for 11.
module ssbg_top
    import ssbg_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic tx_enable_i,
    input wire logic rx_enable_i,
    input wire logic tx_data_write_i,
    input wire logic tx_load_i,
    input wire logic tx_last_bit_i,
    input wire logic rx_done_ok_i,
    input wire logic rx_overrun_i,
    input wire logic rx_framing_i,
    input wire logic rx_parity_i,
    input wire logic rx_data_read_i,
    input wire logic rx_char_done_i,
    input wire logic rx_mpb_i,
    output logic tx_buffer_empty_o,
    output logic rx_buffer_full_o,
    output logic overrun_flag_o,
    output logic framing_flag_o,
    output logic parity_flag_o,
    output logic tx_complete_o,
    output logic rx_multiproc_bit_o,
    output logic tx_multiproc_bit_o,
    output logic bit_tick_o
);
    logic sts_wr;
    logic sts_rd;
    logic div_wr;
    logic ctl_wr;
    logic [7:0] flag_set;
    logic [7:0] flag_hw_clr;
    logic [7:0] flag_q;
    logic [7:0] status_val;
    logic [7:0] bit_rate_divisor_reg;
    logic [7:0] control_reg;
    logic rx_mpb_reg;
    logic tx_mpb_reg;
    logic [7:0] rdata_reg;

    ssbg_baud_if baud_bus ();

    // ==========================================================
    // register decode
    assign sts_wr = wr_i && (addr_i == SSBG_STATUS_ADDR);
    assign sts_rd = rd_i && (addr_i == SSBG_STATUS_ADDR);
    assign div_wr = wr_i && (addr_i == SSBG_DIVISOR_ADDR);
    assign ctl_wr = wr_i && (addr_i == SSBG_CONTROL_ADDR);

    // ==========================================================
    // status flag sources
    always_comb begin
        flag_set = 8'h00;
        flag_hw_clr = 8'h00;
        flag_set[SSBG_TX_EMPTY_BIT] = !tx_enable_i || tx_load_i;
        flag_hw_clr[SSBG_TX_EMPTY_BIT] = tx_data_write_i;
        flag_set[SSBG_RX_FULL_BIT] = rx_done_ok_i;
        flag_hw_clr[SSBG_RX_FULL_BIT] = rx_data_read_i;
        flag_set[SSBG_OVERRUN_BIT] = rx_overrun_i;
        flag_set[SSBG_FRAMING_BIT] = rx_framing_i;
        flag_set[SSBG_PARITY_BIT] = rx_parity_i;
        flag_set[SSBG_TX_DONE_BIT] = !tx_enable_i
            || (tx_last_bit_i && flag_q[SSBG_TX_EMPTY_BIT]);
        flag_hw_clr[SSBG_TX_DONE_BIT] = tx_data_write_i;
    end

    // one cell per sticky flag; each clears on a 0 only, so a 1 is ignored
    for (genvar i = SSBG_TX_DONE_BIT; i <= SSBG_TX_EMPTY_BIT; i++) begin : g_flag
        ssbg_flag_cell #(
            .RESET_VAL(SSBG_STATUS_RESET[i])
        ) u_cell (
            .clock_i(clock_i),
            .rstn_i(rstn_i),
            .set_i(flag_set[i]),
            .hw_clr_i(flag_hw_clr[i]),
            .sts_rd_i(sts_rd),
            .sts_wr_i(sts_wr),
            .wbit_i(wdata_i[i]),
            .flag_o(flag_q[i])
        );
    end
    assign flag_q[1:0] = 2'b00;

    // ==========================================================
    // multiprocessor bits
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_mpb_reg <= SSBG_STATUS_RESET[SSBG_RX_MPB_BIT];
        end else if (rx_char_done_i && rx_enable_i) begin
            rx_mpb_reg <= rx_mpb_i;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_mpb_reg <= SSBG_STATUS_RESET[SSBG_TX_MPB_BIT];
        end else if (sts_wr) begin
            tx_mpb_reg <= wdata_i[SSBG_TX_MPB_BIT];
        end
    end

    // ==========================================================
    // divisor and baud control
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bit_rate_divisor_reg <= SSBG_DIVISOR_RESET;
        end else if (div_wr) begin
            bit_rate_divisor_reg <= wdata_i;
        end
    end

    // reserved control bits read back as zero
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            control_reg <= SSBG_CONTROL_RESET;
        end else if (ctl_wr) begin
            control_reg <= 8'h00;
            control_reg[SSBG_SYNC_MODE_BIT] <= wdata_i[SSBG_SYNC_MODE_BIT];
            control_reg[SSBG_PRESCALE_LSB +: 2] <= wdata_i[SSBG_PRESCALE_LSB +: 2];
        end
    end

    // a rate change restarts the divider; after a divisor write the first divider count still uses the old divisor
    assign baud_bus.divisor = bit_rate_divisor_reg;
    assign baud_bus.prescale = control_reg[SSBG_PRESCALE_LSB +: 2];
    assign baud_bus.sync_mode = control_reg[SSBG_SYNC_MODE_BIT];
    assign baud_bus.restart = div_wr || ctl_wr;

    ssbg_baud_gen u_baud (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .baud(baud_bus.gen)
    );

    // sync mode at prescale 0, divisor 0 still ticks; continuous use is software's care
    assign bit_tick_o = baud_bus.bit_tick;

    // ==========================================================
    // read port
    always_comb begin
        status_val = flag_q;
        status_val[SSBG_RX_MPB_BIT] = rx_mpb_reg;
        status_val[SSBG_TX_MPB_BIT] = tx_mpb_reg;
    end

    // data stand for one cycle only; unmapped addresses read zero
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                SSBG_STATUS_ADDR: rdata_reg <= status_val;
                SSBG_DIVISOR_ADDR: rdata_reg <= bit_rate_divisor_reg;
                SSBG_CONTROL_ADDR: rdata_reg <= control_reg;
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign rdata_o = rdata_reg;
    assign tx_buffer_empty_o = flag_q[SSBG_TX_EMPTY_BIT];
    assign rx_buffer_full_o = flag_q[SSBG_RX_FULL_BIT];
    assign overrun_flag_o = flag_q[SSBG_OVERRUN_BIT];
    assign framing_flag_o = flag_q[SSBG_FRAMING_BIT];
    assign parity_flag_o = flag_q[SSBG_PARITY_BIT];
    assign tx_complete_o = flag_q[SSBG_TX_DONE_BIT];
    assign rx_multiproc_bit_o = rx_mpb_reg;
    assign tx_multiproc_bit_o = tx_mpb_reg;

    // ==========================================================
    // checking
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    sequence read_one(int b);
        sts_rd && status_val[b];
    endsequence

    sequence write_zero(int b);
        sts_wr && !wdata_i[b];
    endsequence

    tx_empty_set_a: assert property ((!tx_enable_i || tx_load_i) |=> tx_buffer_empty_o)
        else $error("tx empty not set");

    tx_empty_clr_a: assert property (
        (tx_data_write_i && tx_enable_i && !tx_load_i) |=> !tx_buffer_empty_o)
        else $error("tx empty not cleared by data write");

    rx_full_set_a: assert property (rx_done_ok_i |=> rx_buffer_full_o)
        else $error("rx full not set");

    rx_full_rise_a: assert property ($rose(rx_buffer_full_o) |-> $past(rx_done_ok_i))
        else $error("rx full set without good byte");

    rx_full_clr_a: assert property (
        read_one(SSBG_RX_FULL_BIT) ##1 (write_zero(SSBG_RX_FULL_BIT) && !rx_done_ok_i)
        |=> !rx_buffer_full_o)
        else $error("rx full not cleared by software");

    overrun_clr_a: assert property (
        read_one(SSBG_OVERRUN_BIT) ##1 (write_zero(SSBG_OVERRUN_BIT) && !rx_overrun_i)
        |=> !overrun_flag_o)
        else $error("overrun not cleared");

    overrun_fall_a: assert property (
        $fell(overrun_flag_o) |-> $past(sts_wr && !wdata_i[SSBG_OVERRUN_BIT]))
        else $error("overrun cleared without write of 0");

    framing_fall_a: assert property (
        $fell(framing_flag_o) |-> $past(sts_wr && !wdata_i[SSBG_FRAMING_BIT]))
        else $error("framing flag cleared without write of 0");

    parity_fall_a: assert property (
        $fell(parity_flag_o) |-> $past(sts_wr && !wdata_i[SSBG_PARITY_BIT]))
        else $error("parity flag cleared without write of 0");

    tx_done_set_a: assert property (
        (tx_last_bit_i && tx_buffer_empty_o) or !tx_enable_i |=> tx_complete_o)
        else $error("tx complete not set");

    tx_done_clr_a: assert property (
        (tx_data_write_i && tx_enable_i && !tx_last_bit_i) |=> !tx_complete_o)
        else $error("tx complete not cleared by data write");

    tx_done_rise_a: assert property (
        $rose(tx_complete_o) |-> $past(!tx_enable_i || tx_last_bit_i))
        else $error("tx complete set by software");

    rx_mpb_hold_a: assert property (!rx_enable_i |=> $stable(rx_multiproc_bit_o))
        else $error("rx multiprocessor bit changed while rx disabled");

    tx_mpb_write_a: assert property (
        sts_wr |=> tx_multiproc_bit_o == $past(wdata_i[SSBG_TX_MPB_BIT]))
        else $error("tx multiprocessor bit not written");

    divisor_read_a: assert property (
        div_wr ##1 (rd_i && addr_i == SSBG_DIVISOR_ADDR && !div_wr)
        |=> rdata_o == $past(wdata_i, 2))
        else $error("divisor readback wrong");

    write_one_a: assert property (
        $rose(overrun_flag_o) || $rose(framing_flag_o) || $rose(parity_flag_o)
        |-> $past(rx_overrun_i || rx_framing_i || rx_parity_i))
        else $error("status flag set by a write");

    set_priority_a: assert property (
        (rx_overrun_i && sts_wr && !wdata_i[SSBG_OVERRUN_BIT]) |=> overrun_flag_o)
        else $error("set lost against clear");
endmodule : ssbg_top

// *** verification/ssbg_far_end.sv ***
`timescale 1ns/1ps
// ==========================================================
// far-end transceiver model: each received frame becomes one-cycle event pulses
module ssbg_far_end (
    input wire logic clock_i,
    output logic done_ok_o,
    output logic overrun_o,
    output logic framing_o,
    output logic parity_o,
    output logic char_done_o,
    output logic mpb_o
);
    initial begin
        {done_ok_o, overrun_o, framing_o, parity_o, char_done_o, mpb_o} = 6'h00;
    end

    // kind 0 good, 1 overrun, 2 framing, 3 parity, 4 character only
    // gap models a slow line between frames
    task automatic send(input int kind, input logic mpb, input int gap);
        repeat (gap) @(posedge clock_i);
        @(posedge clock_i);
        done_ok_o <= (kind == 0);
        overrun_o <= (kind == 1);
        framing_o <= (kind == 2);
        parity_o <= (kind == 3);
        char_done_o <= 1'b1;
        mpb_o <= mpb;
        @(posedge clock_i);
        {done_ok_o, overrun_o, framing_o, parity_o, char_done_o} <= 5'h00;
        // the bit is stale after the frame, so do not leave the old value up
        mpb_o <= ~mpb;
    endtask : send
endmodule : ssbg_far_end

// *** verification/serial_status_and_baud_gen_tb.sv ***
`timescale 1ns/1ps
module serial_status_and_baud_gen_tb;
    logic clk, rstn, wr, rd, txen, rxen;
    logic [1:0] addr;
    logic [7:0] wdata, m_st, armed;
    logic [3:0] tb_ev;
    wire logic [7:0] rdata, fl;
    wire logic tick, ok_e, ovr_e, fr_e, par_e, chr_e, mpb_e;
    int n_errors, num_checks, seed;

    // ==========================================================
    // design and far end
    ssbg_top ssbg_top_inst (.clock_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .tx_enable_i(txen), .rx_enable_i(rxen),
        .tx_data_write_i(tb_ev[0]), .tx_load_i(tb_ev[1]), .tx_last_bit_i(tb_ev[2]),
        .rx_done_ok_i(ok_e), .rx_overrun_i(ovr_e), .rx_framing_i(fr_e),
        .rx_parity_i(par_e), .rx_data_read_i(tb_ev[3]), .rx_char_done_i(chr_e),
        .rx_mpb_i(mpb_e), .tx_buffer_empty_o(fl[7]), .rx_buffer_full_o(fl[6]),
        .overrun_flag_o(fl[5]), .framing_flag_o(fl[4]), .parity_flag_o(fl[3]),
        .tx_complete_o(fl[2]), .rx_multiproc_bit_o(fl[1]), .tx_multiproc_bit_o(fl[0]),
        .bit_tick_o(tick));
    ssbg_far_end ssbg_far_end_inst (.clock_i(clk), .done_ok_o(ok_e), .overrun_o(ovr_e),
        .framing_o(fr_e), .parity_o(par_e), .char_done_o(chr_e), .mpb_o(mpb_e));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================================
    // checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic cmp();
        chk("flags", 32'(m_st), 32'(fl));
    endtask : cmp

    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
        if (a == 2'h0) begin
            // only armed bits written as 0 clear; any status write disarms
            m_st[7:2] = m_st[7:2] & ~(armed[7:2] & ~d[7:2]);
            m_st[0] = d[0];
            armed = 8'h00;
        end
        // a frame ending at the same edge updates the model at +2, so compare after it
        #2;
        cmp();
    endtask : wr_reg

    // status read then write with no gap, as a polling loop would do it
    task automatic rd_wr(input logic [7:0] d);
        logic [7:0] e;
        e = m_st;
        @(posedge clk);
        addr <= 2'h0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        wdata <= d;
        wr <= 1'b1;
        #1;
        chk("rdata", 32'(e), 32'(rdata));
        armed = m_st & 8'hfc;
        @(posedge clk);
        wr <= 1'b0;
        #1;
        m_st[7:2] = m_st[7:2] & ~(armed[7:2] & ~d[7:2]);
        m_st[0] = d[0];
        armed = 8'h00;
        cmp();
        chk("rdata_idle", 32'h0, 32'(rdata));
    endtask : rd_wr

    // register write then read back with no gap; not for the status address
    task automatic wr_rd(input logic [1:0] a, input logic [7:0] d, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", 32'(e), 32'(rdata));
        @(posedge clk);
        #1;
        chk("rdata_idle", 32'h0, 32'(rdata));
    endtask : wr_rd

    task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", 32'(e), 32'(rdata));
        if (a == 2'h0) armed = m_st & 8'hfc;
        @(posedge clk);
        #1;
        chk("rdata_idle", 32'h0, 32'(rdata));
    endtask : rd_reg

    // 0 tx data write, 1 tx load, 2 tx last bit, 3 rx holding read
    task automatic tev(input int i);
        @(posedge clk);
        tb_ev <= 4'(1 << i);
        @(posedge clk);
        tb_ev <= 4'h0;
        #1;
        case (i)
            0: begin
                m_st[7] = 1'b0;
                m_st[2] = 1'b0;
            end
            1: m_st[7] = 1'b1;
            2: if (m_st[7]) m_st[2] = 1'b1;
            default: m_st[6] = 1'b0;
        endcase
        cmp();
    endtask : tev

    task automatic rx(input int kind, input logic mpb, input int gap);
        ssbg_far_end_inst.send(kind, mpb, gap);
        // later than a write ending at the same edge: a set wins over a clear
        #2;
        if (kind < 4) m_st[6 - kind] = 1'b1;
        if (rxen) m_st[1] = mpb;
        cmp();
    endtask : rx

    task automatic baud(input logic md, input logic [1:0] n, input logic [7:0] dv);
        int c, e;
        wr_rd(2'h1, dv, dv);
        // reserved control bits are written as ones and must read back as zero
        wr_reg(2'h2, {md, 5'h1f, n});
        rd_reg(2'h2, {md, 5'h00, n});
        e = (int'(dv) + 1) * (1 << (2 * n)) * (md ? 4 : 32);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (tick !== 1'b1 && c < 25000);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (tick !== 1'b1 && c < 25000);
        chk("bit_period", 32'(e), 32'(c));
    endtask : baud

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // watchdog: the longest run is the baud sweep, well below this
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    // ==========================================================
    // main sequence
    initial begin
        {rstn, wr, rd, addr, wdata, tb_ev} = '0;
        {txen, rxen} = 2'b11;
        m_st = 8'h84;
        armed = 8'h00;
        seed = 32'h8108;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        #1;
        cmp();
        rd_reg(2'h0, m_st);
        rd_reg(2'h1, 8'hff);
        wr_reg(2'h3, 8'h55);
        rd_reg(2'h3, 8'h00);
        for (int k = 1; k < 4; k++) begin
            rx(k, 1'b0, k);
            wr_reg(2'h0, 8'hff);
            wr_reg(2'h0, 8'h00);
            rd_wr(8'h00);
        end
        rx(0, 1'b1, 5);
        tev(3);
        rx(0, 1'b0, 0);
        rd_wr(8'h01);
        rx(1, 1'b0, 0);
        rd_reg(2'h0, m_st);
        fork
            wr_reg(2'h0, 8'h00);
            rx(1, 1'b0, 0);
        join
        @(posedge clk);
        rxen <= 1'b0;
        rx(4, 1'b1, 0);
        @(posedge clk);
        rxen <= 1'b1;
        tev(1);
        tev(0);
        tev(2);
        tev(1);
        tev(2);
        tev(0);
        @(posedge clk);
        txen <= 1'b0;
        @(posedge clk);
        txen <= 1'b1;
        #1;
        m_st[7] = 1'b1;
        m_st[2] = 1'b1;
        cmp();
        wr_reg(2'h1, 8'($random(seed)));
        baud(1'b0, 2'h0, 8'h00);
        for (int m = 0; m < 2; m++) begin
            for (int n = 0; n < 4; n++) begin
                // nonzero divisor keeps clocked sync mode off its fastest setting
                baud(1'(m), 2'(n), 8'(1 + ($random(seed) & 3)));
            end
        end
        tally_and_finish();
    end
endmodule : serial_status_and_baud_gen_tb
